// >>> logic/sadc_pkg.sv
// Purpose: Shared constants for the slope converter timer and capture block.
// Assumes: APB with 32-bit data; printed offsets are word indices.
// Notes:   Byte address of each register is four times its index.
package sadc_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_CNT_LOW   = 10'h00E;
  localparam logic [IDX_W-1:0] IDX_CNT_HIGH  = 10'h00F;
  localparam logic [IDX_W-1:0] IDX_CAP_LOW   = 10'h015;
  localparam logic [IDX_W-1:0] IDX_CAP_HIGH  = 10'h016;
  localparam logic [IDX_W-1:0] IDX_CTRL0     = 10'h01F;
  localparam logic [IDX_W-1:0] IDX_CTRL1     = 10'h09F;
  localparam logic [IDX_W-1:0] IDX_INTCTRL   = 10'h00B;
  localparam logic [IDX_W-1:0] IDX_PFLAG     = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_PENABLE   = 10'h08C;
  localparam logic [IDX_W-1:0] IDX_SLEEP     = 10'h08F;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned CTRL0_CHAN_LSB   = 4;
  localparam int unsigned CTRL0_RAMP_RST   = 1;
  localparam int unsigned CTRL1_CUR_LSB    = 4;
  localparam int unsigned SLP_REF_DISABLE  = 5;
  localparam int unsigned SLP_CONV_DISABLE = 0;
  localparam int unsigned FLAG_CAPTURE     = 1;
  localparam int unsigned FLAG_OVERFLOW    = 0;
  localparam int unsigned INTC_GLOBAL      = 7;
  localparam int unsigned INTC_PERIPH      = 6;

  // ************************************************************
  // Reset and mask values
  // ************************************************************
  localparam logic [7:0]  CTRL0_RESET    = 8'h02;
  localparam logic [7:0]  CTRL0_WR_MASK  = 8'hF7;
  localparam logic [7:0]  CTRL1_RESET    = 8'h00;
  localparam logic [7:0]  SLEEP_RESET    = 8'h21;
  localparam logic [7:0]  SLEEP_WR_MASK  = 8'h21;
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;

  // ************************************************************
  // Channel codes and source lines
  // ************************************************************
  localparam logic [3:0] CH_EXT_LOW_LAST  = 4'h3;
  localparam logic [3:0] CH_BANDGAP       = 4'h4;
  localparam logic [3:0] CH_SLOPE_REF_HI  = 4'h5;
  localparam logic [3:0] CH_SLOPE_REF_LO  = 4'h6;
  localparam logic [3:0] CH_TEMP          = 4'h7;
  localparam logic [3:0] CH_PREF_A        = 4'h8;
  localparam logic [3:0] CH_PREF_B        = 4'h9;
  localparam logic [3:0] CH_EXT_HIGH_1ST  = 4'hA;
  localparam logic [3:0] CH_EXT_HIGH_LAST = 4'hD;
  localparam int unsigned SRC_BANDGAP     = 8;
  localparam int unsigned SRC_SLOPE_HI    = 9;
  localparam int unsigned SRC_SLOPE_LO    = 10;
  localparam int unsigned SRC_TEMP        = 11;
  localparam int unsigned SRC_PREF_A      = 12;
  localparam int unsigned SRC_PREF_B      = 13;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_MHZ         = 10;
  localparam int unsigned DISCHARGE_US    = 200;
  localparam int unsigned DISCHARGE_CYC   = DISCHARGE_US * CLK_MHZ;
  localparam logic [10:0] DISCHARGE_LAST  = 11'(DISCHARGE_CYC);

endpackage : sadc_pkg

// >>> logic/sadc_capture_top.sv
// Purpose: Counter, capture and control registers of a single-slope converter.
// Assumes: One 10 MHz clock; comparator input is asynchronous.
// Notes:   APB slave, zero wait states, read data sampled in the setup cycle.
//
// Overview of operation
// - Sixteen-bit counter adds one each clock unless ramp reset, sleep or a pending high-byte write holds it.
// - Clearing ramp reset starts counting and ramp charging together.
// - Comparator falling edge copies the counter into the capture register.
// - Counter keeps counting after a capture.
// - A capture sets the capture flag, bit 1 of the flag register.
// - Capture request needs capture, global and peripheral enables all set.
// - At most one capture per conversion cycle.
// - Wrap from FFFFh to 0000h sets the overflow flag, bit 0, unless a write to either counter byte lands in the same cycle.
// - Counter keeps counting from zero after a wrap.
// - Overflow request needs overflow, global and peripheral enables all set.
// - Reset clears the counter; only counting or writes change it afterwards.
// - Counter and capture register are byte pairs at 0Eh/0Fh and 15h/16h.
// - Counter spans 65,536 states, clocked by the system oscillator.
// - Four-bit channel code selects one of fourteen sources; two reserved.
// - Ramp reset is control 0 bit 1, resets to one, stops the counter.
// - Ramp current sources are off while ramp reset is set.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module sadc_capture_top
  import sadc_pkg::*;
(
  input  wire logic                      sys_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [sadc_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      comparator_i,
  output logic      [3:0]                channel_select_o,
  output logic      [15:0]               source_onehot_o,
  output logic      [3:0]                current_select_o,
  output logic                           ramp_discharge_o,
  output logic                           ramp_discharged_o,
  output logic                           reference_enable_o,
  output logic                           converter_enable_o,
  output logic                           capture_irq_o,
  output logic                           overflow_irq_o
);
  import sadc_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0]  hi_hold;
    logic        load_pend;
    logic [15:0] cap;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  sleep;
    logic [1:0]  flags;
    logic [1:0]  enables;
    logic        gie;
    logic        peie;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        cmp_prev;
    logic        captured;
    logic [10:0] dis_cnt;
    logic [31:0] rdata;
    logic        cap_irq;
    logic        ovf_irq;
  } sadc_state_s;

  sadc_state_s st_q;
  sadc_state_s st_d;

  logic             wr_en;
  logic             rd_setup;
  logic [IDX_W-1:0] idx;
  logic             mapped;
  logic             ramp_rst;
  logic             conv_en;
  logic             run;
  logic             cap_evt;
  logic             ovf_evt;
  logic             wr_cnt_lo;
  logic             wr_cnt_hi;
  logic [31:0]      rd_val;

  // ************************************************************
  // Bus decode and control terms
  // ************************************************************
  always_comb
  begin
    idx       = paddr_i[ADDR_W-1:2];
    mapped    = (idx == IDX_CNT_LOW) || (idx == IDX_CNT_HIGH) || (idx == IDX_CAP_LOW) ||
                (idx == IDX_CAP_HIGH) || (idx == IDX_CTRL0) || (idx == IDX_CTRL1) ||
                (idx == IDX_INTCTRL) || (idx == IDX_PFLAG) || (idx == IDX_PENABLE) ||
                (idx == IDX_SLEEP);
    wr_en     = psel_i && penable_i && pwrite_i && pstrb_i[0] && mapped;
    rd_setup  = psel_i && !penable_i && !pwrite_i;
    wr_cnt_lo = wr_en && (idx == IDX_CNT_LOW);
    wr_cnt_hi = wr_en && (idx == IDX_CNT_HIGH);
    ramp_rst  = st_q.ctrl0[CTRL0_RAMP_RST];
    conv_en   = !st_q.sleep[SLP_REF_DISABLE] && !st_q.sleep[SLP_CONV_DISABLE];
    run       = conv_en && !ramp_rst && !st_q.load_pend;
    cap_evt   = run && st_q.cmp_prev && !st_q.cmp_s2 && !st_q.captured;
    ovf_evt   = run && (st_q.cnt == CNT_MAX) && !wr_cnt_lo && !wr_cnt_hi;
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (idx == IDX_CNT_LOW)
    begin
      rd_val[7:0] = st_q.cnt[7:0];
    end
    else if (idx == IDX_CNT_HIGH)
    begin
      rd_val[7:0] = st_q.cnt[15:8];
    end
    else if (idx == IDX_CAP_LOW)
    begin
      rd_val[7:0] = st_q.cap[7:0];
    end
    else if (idx == IDX_CAP_HIGH)
    begin
      rd_val[7:0] = st_q.cap[15:8];
    end
    else if (idx == IDX_CTRL0)
    begin
      rd_val[7:0] = st_q.ctrl0;
    end
    else if (idx == IDX_CTRL1)
    begin
      rd_val[7:0] = st_q.ctrl1;
    end
    else if (idx == IDX_INTCTRL)
    begin
      rd_val[INTC_GLOBAL] = st_q.gie;
      rd_val[INTC_PERIPH] = st_q.peie;
    end
    else if (idx == IDX_PFLAG)
    begin
      rd_val[1:0] = st_q.flags;
    end
    else if (idx == IDX_PENABLE)
    begin
      rd_val[1:0] = st_q.enables;
    end
    else if (idx == IDX_SLEEP)
    begin
      rd_val[7:0] = st_q.sleep;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    // Comparator synchroniser and edge history.
    st_d.cmp_s1   = comparator_i;
    st_d.cmp_s2   = st_q.cmp_s1;
    st_d.cmp_prev = st_q.cmp_s2;

    // Counting wraps naturally through all 65,536 states.
    if (run)
    begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end

    // Ramp reset re-arms the single capture of a conversion cycle.
    if (ramp_rst)
    begin
      st_d.captured = 1'b0;
    end
    else if (cap_evt)
    begin
      st_d.captured = 1'b1;
    end
    if (cap_evt)
    begin
      st_d.cap = st_q.cnt;
    end

    // Discharge time is counted while ramp reset stays set.
    if (!ramp_rst)
    begin
      st_d.dis_cnt = 11'h000;
    end
    else if (st_q.dis_cnt != DISCHARGE_LAST)
    begin
      st_d.dis_cnt = st_q.dis_cnt + 11'h001;
    end

    if (wr_cnt_hi)
    begin
      st_d.hi_hold   = pwdata_i[7:0];
      st_d.load_pend = 1'b1;
    end
    if (wr_cnt_lo)
    begin
      st_d.cnt       = st_q.load_pend ? {st_q.hi_hold, pwdata_i[7:0]}
                                      : {st_q.cnt[15:8], pwdata_i[7:0]};
      st_d.load_pend = 1'b0;
    end
    if (wr_en && (idx == IDX_CAP_LOW))
    begin
      st_d.cap[7:0] = pwdata_i[7:0];
    end
    if (wr_en && (idx == IDX_CAP_HIGH))
    begin
      st_d.cap[15:8] = pwdata_i[7:0];
    end
    if (wr_en && (idx == IDX_CTRL0))
    begin
      st_d.ctrl0 = pwdata_i[7:0] & CTRL0_WR_MASK;
    end
    if (wr_en && (idx == IDX_CTRL1))
    begin
      st_d.ctrl1 = pwdata_i[7:0];
    end
    if (wr_en && (idx == IDX_INTCTRL))
    begin
      st_d.gie  = pwdata_i[INTC_GLOBAL];
      st_d.peie = pwdata_i[INTC_PERIPH];
    end
    if (wr_en && (idx == IDX_PENABLE))
    begin
      st_d.enables = pwdata_i[1:0];
    end
    if (wr_en && (idx == IDX_SLEEP))
    begin
      st_d.sleep = pwdata_i[7:0] & SLEEP_WR_MASK;
    end

    // Flags: a hardware set in the same cycle as a software clear wins.
    if (wr_en && (idx == IDX_PFLAG))
    begin
      st_d.flags = pwdata_i[1:0];
    end
    if (cap_evt)
    begin
      st_d.flags[FLAG_CAPTURE] = 1'b1;
    end
    if (ovf_evt)
    begin
      st_d.flags[FLAG_OVERFLOW] = 1'b1;
    end

    st_d.cap_irq = st_q.flags[FLAG_CAPTURE] && st_q.enables[FLAG_CAPTURE] &&
                   st_q.gie && st_q.peie;
    st_d.ovf_irq = st_q.flags[FLAG_OVERFLOW] && st_q.enables[FLAG_OVERFLOW] &&
                   st_q.gie && st_q.peie;

    if (rd_setup)
    begin
      st_d.rdata = rd_val;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_q       <= '0;
      st_q.cnt   <= CNT_RESET;
      st_q.ctrl0 <= CTRL0_RESET;
      st_q.ctrl1 <= CTRL1_RESET;
      st_q.sleep <= SLEEP_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Channel decode
  // ************************************************************
  always_comb
  begin
    logic [3:0] ch;
    ch              = st_q.ctrl0[CTRL0_CHAN_LSB +: 4];
    source_onehot_o = 16'h0000;
    if (ch <= CH_EXT_LOW_LAST)
    begin
      source_onehot_o[ch] = 1'b1;
    end
    else if (ch == CH_BANDGAP)
    begin
      source_onehot_o[SRC_BANDGAP] = 1'b1;
    end
    else if (ch == CH_SLOPE_REF_HI)
    begin
      source_onehot_o[SRC_SLOPE_HI] = 1'b1;
    end
    else if (ch == CH_SLOPE_REF_LO)
    begin
      source_onehot_o[SRC_SLOPE_LO] = 1'b1;
    end
    else if (ch == CH_TEMP)
    begin
      source_onehot_o[SRC_TEMP] = 1'b1;
    end
    else if (ch == CH_PREF_A)
    begin
      source_onehot_o[SRC_PREF_A] = 1'b1;
    end
    else if (ch == CH_PREF_B)
    begin
      source_onehot_o[SRC_PREF_B] = 1'b1;
    end
    else if (ch <= CH_EXT_HIGH_LAST)
    begin
      source_onehot_o[ch - CH_EXT_HIGH_1ST + 4'h4] = 1'b1;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata_o           = st_q.rdata;
  assign pready_o           = 1'b1;
  assign pslverr_o          = psel_i && penable_i && !mapped;
  assign channel_select_o   = st_q.ctrl0[CTRL0_CHAN_LSB +: 4];
  assign current_select_o   = ramp_rst ? 4'h0 : st_q.ctrl1[CTRL1_CUR_LSB +: 4];
  assign ramp_discharge_o   = ramp_rst;
  assign ramp_discharged_o  = ramp_rst && (st_q.dis_cnt == DISCHARGE_LAST);
  assign reference_enable_o = !st_q.sleep[SLP_REF_DISABLE];
  assign converter_enable_o = conv_en;
  assign capture_irq_o      = st_q.cap_irq;
  assign overflow_irq_o     = st_q.ovf_irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_count_step;
    run && !wr_cnt_lo |=> st_q.cnt == $past(st_q.cnt) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_hold_in_reset;
    ramp_rst && !wr_cnt_lo |=> $stable(st_q.cnt);
  endproperty
  a_hold_in_reset: assert property (p_hold_in_reset) else $error("count moved");

  property p_start;
    $fell(ramp_rst) && conv_en && !st_q.load_pend && !wr_cnt_lo |=> $changed(st_q.cnt);
  endproperty
  a_start: assert property (p_start) else $error("count did not start");

  property p_capture;
    cap_evt |=> st_q.cap == $past(st_q.cnt) && st_q.flags[FLAG_CAPTURE];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  property p_sync_edge;
    cap_evt |-> $past(comparator_i, 3) && !$past(comparator_i, 2);
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("edge not synchronised");

  property p_once;
    cap_evt |=> (!cap_evt || ramp_rst)[*8];
  endproperty
  a_once: assert property (p_once) else $error("second capture");

  property p_wrap;
    ovf_evt |=> st_q.cnt == CNT_RESET && st_q.flags[FLAG_OVERFLOW];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not flagged");

  property p_cap_irq;
    st_q.flags[FLAG_CAPTURE] && st_q.enables[FLAG_CAPTURE] && st_q.gie && st_q.peie
      |=> capture_irq_o;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture request missing");

  property p_ovf_irq;
    overflow_irq_o |-> $past(st_q.enables[FLAG_OVERFLOW]) && $past(st_q.gie)
      && $past(st_q.peie) && $past(st_q.flags[FLAG_OVERFLOW]);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request unqualified");

  property p_pending;
    wr_cnt_hi ##1 !wr_cnt_lo |-> st_q.load_pend ##1 $stable(st_q.cnt);
  endproperty
  a_pending: assert property (p_pending) else $error("high write not held");

  property p_current_off;
    ramp_rst |-> current_select_o == 4'h0;
  endproperty
  a_current_off: assert property (p_current_off) else $error("current on in reset");

  c_capture:  cover property (cap_evt);
  c_overflow: cover property (ovf_evt);
  c_load:     cover property (wr_cnt_hi ##[1:20] wr_cnt_lo);
  c_irq:      cover property (capture_irq_o);

endmodule : sadc_capture_top

// >>> testbench/sadc_ramp_model.sv
// Purpose: Ramp capacitor and comparator that face the converter block.
// Assumes: The ramp rises by the current code on each clock unless discharged.
// Notes:   With bounce set the output keeps toggling after the trip.
`timescale 1ns/100ps
module sadc_ramp_model
(
  input  wire logic        clk_i,
  input  wire logic        discharge_i,
  input  wire logic [3:0]  current_i,
  input  wire logic [19:0] level_i,
  input  wire logic        bounce_i,
  output logic             comp_o
);
  logic [19:0] ramp_q = 20'h0_0000;
  initial comp_o = 1'b1;
  always @(posedge clk_i)
  begin
    if (discharge_i)
      ramp_q <= 20'h0_0000;
    else
      ramp_q <= ramp_q + 20'(current_i);
  end
  always @(posedge clk_i)
  begin
    if (ramp_q < level_i)
      comp_o <= 1'b1;
    else if (bounce_i)
      comp_o <= ~comp_o;
    else
      comp_o <= 1'b0;
  end
endmodule : sadc_ramp_model

// >>> testbench/test_slope_adc_timer_capture.sv
// Purpose: Self-checking bench for the slope converter timer and capture block.
// Assumes: 10 MHz clock; APB master waits for pready.
// Notes:   Capture values are judged within a small window.
`timescale 1ns/100ps
module test_slope_adc_timer_capture;
  import sadc_pkg::*;
  logic              clk    = 1'b0;
  logic              rst    = 1'b1;
  logic              psel   = 1'b0;
  logic              pen    = 1'b0;
  logic              pwr    = 1'b0;
  logic [ADDR_W-1:0] paddr  = '0;
  logic [31:0]       pwdata = '0;
  logic [3:0]        pstrb  = 4'h0;
  logic [19:0]       level  = 20'h0_0028;
  logic              bounce = 1'b0;
  logic              comp;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [3:0]        chan;
  logic [15:0]       onehot;
  logic [3:0]        cur;
  logic              disch;
  logic              dischd;
  logic              refen;
  logic              conven;
  logic              cirq;
  logic              oirq;
  int                n_fail    = 0;
  int                tests_run = 0;
  int                cyc       = 0;

  always #50 clk = ~clk;

  sadc_capture_top DUT (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .comparator_i(comp), .channel_select_o(chan),
    .source_onehot_o(onehot), .current_select_o(cur), .ramp_discharge_o(disch),
    .ramp_discharged_o(dischd), .reference_enable_o(refen), .converter_enable_o(conven),
    .capture_irq_o(cirq), .overflow_irq_o(oirq));

  sadc_ramp_model ramp (.clk_i(clk), .discharge_i(disch), .current_i(cur), .level_i(level),
    .bounce_i(bounce), .comp_o(comp));

  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex)
    begin
      n_fail++;
      $display("wrong value %s expected %h got %h", nm, ex, got);
    end
  endtask : chk

  task automatic near(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if ((^got === 1'bx) || got + 16'h0004 < ex || got > ex + 16'h0004)
    begin
      n_fail++;
      $display("wrong value %s expected %h got %h", nm, ex, got);
    end
  endtask : near

  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    pstrb  <= 4'h1;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, idx, d, rd, er);
  endtask : wr

  task automatic rdw(input logic [IDX_W-1:0] idx, output logic [31:0] rd);
    logic er;
    apb(1'b0, idx, 8'h00, rd, er);
  endtask : rdw

  task automatic rdchk(input string nm, input logic [IDX_W-1:0] idx, input logic [7:0] ex);
    logic [31:0] rd;
    rdw(idx, rd);
    chk(nm, {24'h00_0000, ex}, rd);
  endtask : rdchk

  task automatic wait_irq(input logic ovf, input int lim);
    int n;
    n = 0;
    while (((ovf ? oirq : cirq) !== 1'b1) && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq

  function automatic logic [15:0] src(input int c);
    if (c < 4) return 16'h0001 << c;
    if (c < 10) return 16'h0001 << (c + 4);
    if (c < 14) return 16'h0001 << (c - 6);
    return 16'h0000;
  endfunction : src

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] rd;
    logic        er;
    rdchk("cnt low", IDX_CNT_LOW, 8'h00);
    rdchk("cnt high", IDX_CNT_HIGH, 8'h00);
    rdchk("cap low", IDX_CAP_LOW, 8'h00);
    rdchk("cap high", IDX_CAP_HIGH, 8'h00);
    rdchk("control0", IDX_CTRL0, 8'h02);
    chk("discharge", 32'h0000_0001, 32'(disch));
    chk("enables reset", 32'h0000_0000, 32'({refen, conven}));
    apb(1'b0, 10'h3FF, 8'h00, rd, er);
    chk("unmapped error", 32'h0000_0001, 32'(er));
    $display("reset test done");
  endtask : t_reset

  task automatic t_sleep_chan();
    wr(IDX_SLEEP, 8'h01);
    @(posedge clk);
    chk("enables", 32'h0000_0002, 32'({refen, conven}));
    wr(IDX_SLEEP, 8'h00);
    @(posedge clk);
    chk("enables", 32'h0000_0003, 32'({refen, conven}));
    for (int c = 0; c < 16; c++)
    begin
      wr(IDX_CTRL0, {4'(c), 4'h2});
      repeat (2) @(posedge clk);
      chk("source", 32'(src(c)), 32'(onehot));
      chk("channel", 32'(c), 32'(chan));
    end
    wr(IDX_CTRL1, 8'h50);
    repeat (2) @(posedge clk);
    chk("current held", 32'h0000_0000, 32'(cur));
    chk("discharged early", 32'h0000_0000, 32'(dischd));
    repeat (2000) @(posedge clk);
    chk("discharged", 32'h0000_0001, 32'(dischd));
    $display("sleep and channel test done");
  endtask : t_sleep_chan

  task automatic t_capture();
    logic [31:0] l;
    logic [31:0] h;
    logic [31:0] a;
    logic [15:0] cap;
    wr(IDX_CNT_HIGH, 8'h01);
    wr(IDX_CNT_LOW, 8'h00);
    wr(IDX_PENABLE, 8'h03);
    wr(IDX_INTCTRL, 8'hC0);
    bounce <= 1'b1;
    wr(IDX_CTRL0, 8'h00);
    repeat (2) @(posedge clk);
    chk("current", 32'h0000_0005, 32'(cur));
    wait_irq(1'b0, 200);
    chk("capture irq", 32'h0000_0001, 32'(cirq));
    rdw(IDX_CAP_LOW, l);
    rdw(IDX_CAP_HIGH, h);
    cap = {h[7:0], l[7:0]};
    near("capture", 16'h010C, cap);
    rdchk("flags", IDX_PFLAG, 8'h02);
    repeat (20) @(posedge clk);
    rdchk("cap again", IDX_CAP_LOW, cap[7:0]);
    rdw(IDX_CNT_LOW, a);
    rdw(IDX_CNT_LOW, l);
    chk("count step", 32'h0000_0003, l - a);
    wr(IDX_INTCTRL, 8'h40);
    repeat (2) @(posedge clk);
    chk("masked irq", 32'h0000_0000, 32'(cirq));
    wr(IDX_INTCTRL, 8'hC0);
    wr(IDX_PFLAG, 8'h00);
    rdchk("flags clear", IDX_PFLAG, 8'h00);
    chk("irq clear", 32'h0000_0000, 32'(cirq));
    bounce <= 1'b0;
    wr(IDX_CTRL0, 8'h02);
    $display("capture test done");
  endtask : t_capture

  task automatic t_overflow();
    level <= 20'hF_FFFF;
    wr(IDX_CNT_HIGH, 8'hFF);
    wr(IDX_CNT_LOW, 8'hF0);
    wr(IDX_PENABLE, 8'h01);
    repeat (2000) @(posedge clk);
    chk("discharged again", 32'h0000_0001, 32'(dischd));
    wr(IDX_CTRL0, 8'h00);
    wait_irq(1'b1, 60);
    chk("overflow irq", 32'h0000_0001, 32'(oirq));
    chk("no capture irq", 32'h0000_0000, 32'(cirq));
    rdchk("flags", IDX_PFLAG, 8'h01);
    wr(IDX_CTRL0, 8'h02);
    rdchk("cnt high wrapped", IDX_CNT_HIGH, 8'h00);
    $display("overflow test done");
  endtask : t_overflow

  task automatic t_order();
    logic [31:0] a;
    logic [31:0] b;
    wr(IDX_CNT_HIGH, 8'h30);
    repeat (2000) @(posedge clk);
    wr(IDX_CTRL0, 8'h00);
    rdw(IDX_CNT_LOW, a);
    rdw(IDX_CNT_LOW, b);
    chk("held count", a, b);
    wr(IDX_CNT_LOW, 8'h07);
    rdw(IDX_CNT_LOW, a);
    near("run count", 16'h0009, a[15:0]);
    rdchk("loaded high", IDX_CNT_HIGH, 8'h30);
    wr(IDX_CTRL0, 8'h02);
    rdw(IDX_CNT_LOW, a);
    rdw(IDX_CNT_LOW, b);
    chk("stopped count", a, b);
    $display("order test done");
  endtask : t_order

  // ************************************************************
  // Sequence and timeout
  // ************************************************************
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sleep_chan();
    t_capture();
    t_overflow();
    t_order();
    wrap_up();
  end
endmodule : test_slope_adc_timer_capture
